// [shared/lpsw_consts.vh]
// constants for the low-power sensor wake sampler
`ifndef LPSW_CONSTS_VH
`define LPSW_CONSTS_VH

// register byte offsets
`define LPSW_OFF_CMP_CTL0 8'h00
`define LPSW_OFF_CMP_CTL1 8'h04
`define LPSW_OFF_CMP_RES 8'h08
`define LPSW_OFF_ADC_MODE 8'h0C
`define LPSW_OFF_ADC_START 8'h10
`define LPSW_OFF_ADC_RESULT 8'h14
`define LPSW_OFF_TK_CTL 8'h18
`define LPSW_OFF_IRQ_CTL 8'h1C
`define LPSW_OFF_IRQ_FLAGS 8'h20
`define LPSW_OFF_TK_CLKSEL 8'h24
`define LPSW_OFF_PWR1 8'h28
`define LPSW_OFF_PWR2 8'h2C
`define LPSW_OFF_CKSTP1 8'h30
`define LPSW_OFF_CKSTP2 8'h34
`define LPSW_OFF_WAKE_CTL 8'h38
`define LPSW_OFF_SLEEP 8'h3C
`define LPSW_OFF_STATUS 8'h40
`define LPSW_OFF_TK_COUNT 8'h44

// comparator control fields
`define LPSW_CC_EN 0
`define LPSW_CC_HYS 1
`define LPSW_CC_REF_LSB 6
`define LPSW_HYST_WIDTH 11'h008

// converter mode fields: [1:0] time, [2] ext trigger, [5:3] channel
`define LPSW_AM_TIME_LSB 0
`define LPSW_AM_EXT 2
`define LPSW_AM_CH_LSB 3
`define LPSW_ADC_CH_LAST 3'h5
`define LPSW_ADC_BASE_CYC 8'h04

// power control fields
`define LPSW_P1_SOFTWARE_STANDBY_BIT 7
`define LPSW_P1_LOW_SPEED_SELECT 6
`define LPSW_P1_TIMER_MODE_BIT_THREE 5
`define LPSW_P1_STS_LSB 0
`define LPSW_P2_MEDIUM_SPEED_SELECT 1
`define LPSW_P2_DIRECT_TRANSFER_BIT 0

// module clock stop bits, 1 = running
`define LPSW_CK_TK 0
`define LPSW_CK_CMP 4
`define LPSW_CK_ADC 5
`define LPSW_CK_WATCH_MASK 8'h1F
`define LPSW_CKSTP_RESET 8'hFF

// wake control bits
`define LPSW_WK_EN 0
`define LPSW_WK_MASK 1

// timing
`define LPSW_CLK_PERIOD_NS 10
`define LPSW_WATCH_HZ 32768
`define LPSW_QUARTER_MS 250
`define LPSW_QUARTER_TICKS ((`LPSW_WATCH_HZ * `LPSW_QUARTER_MS) / 1000)
`define LPSW_SETTLE_BASE_NS 160
`define LPSW_SETTLE_BASE_CYC ((`LPSW_SETTLE_BASE_NS + `LPSW_CLK_PERIOD_NS - 1) / `LPSW_CLK_PERIOD_NS)

`endif

// [src/lpsw_sar.v]
// successive approximation engine of the converter
`timescale 1ns/1ps
`default_nettype none
module lpsw_sar (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire stop,
  input wire [7:0] bit_cycles,
  input wire cmp_in,
  output reg [9:0] dac_code,
  output reg busy,
  output reg done,
  output reg [9:0] result
);
  reg [3:0] bit_idx;
  reg [7:0] cnt;
  wire [9:0] cur_bit;
  wire [9:0] kept;
  assign cur_bit = 10'h001 << bit_idx;
  // analog at or above the trial code keeps the bit
  assign kept = cmp_in ? dac_code : (dac_code & ~cur_bit);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code <= 10'h000;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 10'h000;
      bit_idx <= 4'h0;
      cnt <= 8'h00;
    end else begin
      done <= 1'b0;
      if (stop) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        bit_idx <= 4'h9;
        dac_code <= 10'h200;
        cnt <= bit_cycles;
      end else if (busy) begin
        if (cnt > 8'h01) begin
          cnt <= cnt - 8'h01;
        end else if (bit_idx == 4'h0) begin
          result <= kept;
          dac_code <= kept;
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          dac_code <= kept | (cur_bit >> 1);
          bit_idx <= bit_idx - 4'h1;
          cnt <= bit_cycles;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [src/lpsw_timekeeper.v]
// timekeeper: quarter-second prescaler, calendar counts, free counter
`timescale 1ns/1ps
`default_nettype none
`include "lpsw_consts.vh"
module lpsw_timekeeper #(
  parameter QUARTER_TICKS = `LPSW_QUARTER_TICKS
) (
  input wire clk,
  input wire rst_n,
  input wire enable,
  input wire clear,
  input wire use_watch,
  input wire watch_tick,
  input wire alt_tick,
  output reg [6:0] events,
  output reg overflow,
  output wire [19:0] count_view
);
  localparam [31:0] Q_LAST = QUARTER_TICKS - 1;
  reg [15:0] pre;
  reg [1:0] qcnt;
  reg [5:0] sec;
  reg [5:0] min;
  reg [4:0] hour;
  reg [2:0] day;
  reg [7:0] frc;
  assign count_view = use_watch ? {day, hour, min, sec} : {12'h000, frc};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 16'h0000;
      qcnt <= 2'h0;
      sec <= 6'h00;
      min <= 6'h00;
      hour <= 5'h00;
      day <= 3'h0;
      frc <= 8'h00;
      events <= 7'h00;
      overflow <= 1'b0;
    end else begin
      events <= 7'h00;
      overflow <= 1'b0;
      if (clear) begin
        pre <= 16'h0000;
        qcnt <= 2'h0;
        sec <= 6'h00;
        min <= 6'h00;
        hour <= 5'h00;
        day <= 3'h0;
        frc <= 8'h00;
      end else if (enable && use_watch && watch_tick) begin
        if (pre == Q_LAST[15:0]) begin
          pre <= 16'h0000;
          qcnt <= qcnt + 2'h1;
          events[0] <= 1'b1;
          events[1] <= qcnt[0];
          if (qcnt == 2'h3) begin
            events[2] <= 1'b1;
            if (sec == 6'h3B) begin
              sec <= 6'h00;
              events[3] <= 1'b1;
              if (min == 6'h3B) begin
                min <= 6'h00;
                events[4] <= 1'b1;
                if (hour == 5'h17) begin
                  hour <= 5'h00;
                  events[5] <= 1'b1;
                  day <= (day == 3'h6) ? 3'h0 : day + 3'h1;
                  events[6] <= (day == 3'h6);
                end else begin
                  hour <= hour + 5'h01;
                end
              end else begin
                min <= min + 6'h01;
              end
            end else begin
              sec <= sec + 6'h01;
            end
          end
        end else begin
          pre <= pre + 16'h0001;
        end
      end else if (enable && !use_watch && alt_tick) begin
        // timekeeping off: plain 8-bit counter
        frc <= frc + 8'h01;
        overflow <= (frc == 8'hFF);
      end
    end
  end
endmodule
`default_nettype wire

// [src/lpsw_top.v]
// top of the low-power sensor wake sampler with its apb register file
`timescale 1ns/1ps
`default_nettype none
`include "lpsw_consts.vh"
// What this block does
// - after setup, software enters watch state
// - quarter-second timekeeper event wakes to sub-active
// - wake handling compares comparator input 0
// - convert only above reference, else back
// - after conversion, return to watch state
// - per-comparator control, readable result register
// - hysteresis select chooses result switching style
// - successive approximation, 10 bits, six channels
// - 16-bit read-only result, top ten bits
// - result held until next conversion completes
// - mode register: time, trigger, channel
// - start register starts and stops conversion
// - timekeeper counts to a week, periodic events
// - first control starts, stops, resets timer
// - per-interval enables set matching flags
// - free-running mode enables overflow interrupt
// - non-watch clock source gives 8-bit counter
// - two clock-stop registers gate each module
// - watch keeps only low-power modules running
// - interrupt exits watch; speed bits pick target
// - mask or disabled wake keeps watch state
// - sleep needs standby, low-speed, two bits clear
module lpsw_top #(
  parameter QUARTER_TICKS = `LPSW_QUARTER_TICKS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [9:0] comparator_input_0,
  input wire [9:0] comparator_input_1,
  input wire watch_tick,
  input wire alt_tick,
  input wire adc_compare,
  input wire adc_ext_trigger,
  output reg [2:0] adc_channel,
  output wire [9:0] adc_dac_code,
  output reg cpu_halted,
  output reg main_osc_run,
  output reg medium_speed,
  output reg [7:0] module_clock_enable_first,
  output reg [7:0] module_clock_enable_second
);
  localparam [4:0] ST_ACTIVE = 5'h01;
  localparam [4:0] ST_WATCH = 5'h02;
  localparam [4:0] ST_SETTLE = 5'h04;
  localparam [4:0] ST_SAMPLE = 5'h08;
  localparam [4:0] ST_CONVERT = 5'h10;
  localparam [31:0] SETTLE_BASE = `LPSW_SETTLE_BASE_CYC;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'h0) && (a <= `LPSW_OFF_TK_COUNT);
    end
  endfunction

  // new comparator level; hysteresis moves the threshold away from the
  // present level so a slow input does not chatter
  function cmp_next;
    input [9:0] vin;
    input [15:0] ctl;
    input prev;
    reg [10:0] v;
    reg [10:0] r;
    begin
      v = {1'b0, vin};
      r = {1'b0, ctl[15:`LPSW_CC_REF_LSB]};
      if (!ctl[`LPSW_CC_HYS])
        cmp_next = v > r;
      else if (prev)
        cmp_next = (v + `LPSW_HYST_WIDTH) > r;
      else
        cmp_next = v > (r + `LPSW_HYST_WIDTH);
    end
  endfunction

  function [11:0] settle_cycles;
    input [2:0] sts;
    begin
      settle_cycles = SETTLE_BASE[11:0] << sts;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  reg [15:0] cmp_ctl0;
  reg [15:0] cmp_ctl1;
  reg [1:0] cmp_res;
  reg [5:0] adc_mode;
  reg [1:0] tk_ctl;
  reg [7:0] irq_ctl;
  reg [7:0] irq_flags;
  reg tk_use_watch;
  reg [7:0] pwr1;
  reg [1:0] pwr2;
  reg [7:0] ckstp1;
  reg [7:0] ckstp2;
  reg [1:0] wake_ctl;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [11:0] settle_cnt;
  reg cmp_sample;
  reg tk_clear;
  reg [31:0] next_rdata;

  wire wr_fire;
  wire rd_setup;
  wire sleep_cmd;
  wire sw_start;
  wire sw_stop;
  wire seq_start;
  wire ext_start;
  wire adc_clk_on;
  wire sar_busy;
  wire sar_done;
  wire [9:0] sar_result;
  wire [6:0] tk_events;
  wire tk_ovf;
  wire [19:0] tk_view;
  wire [7:0] flag_set;
  wire wake_ok;
  wire sleep_ok;
  wire [7:0] bit_cycles;

  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_setup = psel & penable & ~pready;
  assign sleep_cmd = wr_fire && (paddr == `LPSW_OFF_SLEEP);
  assign adc_clk_on = ckstp1[`LPSW_CK_ADC];
  assign sw_start = wr_fire && (paddr == `LPSW_OFF_ADC_START) &&
                    pwdata[0] && adc_clk_on;
  assign sw_stop = wr_fire && (paddr == `LPSW_OFF_ADC_START) &&
                   !pwdata[0];
  assign ext_start = adc_mode[`LPSW_AM_EXT] && adc_ext_trigger &&
                     adc_clk_on && !sar_busy;
  assign seq_start = (state == ST_SAMPLE) && cmp_sample && adc_clk_on;
  assign bit_cycles = `LPSW_ADC_BASE_CYC <<
                      adc_mode[`LPSW_AM_TIME_LSB +: 2];
  assign flag_set = {tk_ovf & irq_ctl[7],
                     tk_events & irq_ctl[6:0]};
  assign wake_ok = (|flag_set) && wake_ctl[`LPSW_WK_EN] &&
                   !wake_ctl[`LPSW_WK_MASK];
  assign sleep_ok = pwr1[`LPSW_P1_SOFTWARE_STANDBY_BIT] && pwr1[`LPSW_P1_LOW_SPEED_SELECT] &&
                    !pwr1[`LPSW_P1_TIMER_MODE_BIT_THREE] &&
                    !pwr2[`LPSW_P2_DIRECT_TRANSFER_BIT];

  ////////////////////////////////////////////////////////////////////////
  lpsw_sar u_sar (
    .clk(pclk),
    .rst_n(presetn),
    .start(sw_start | seq_start | ext_start),
    .stop(sw_stop),
    .bit_cycles(bit_cycles),
    .cmp_in(adc_compare),
    .dac_code(adc_dac_code),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result)
  );

  lpsw_timekeeper #(
    .QUARTER_TICKS(QUARTER_TICKS)
  ) u_tk (
    .clk(pclk),
    .rst_n(presetn),
    .enable(tk_ctl[0] & ckstp1[`LPSW_CK_TK]),
    .clear(tk_clear),
    .use_watch(tk_use_watch),
    .watch_tick(watch_tick),
    .alt_tick(alt_tick),
    .events(tk_events),
    .overflow(tk_ovf),
    .count_view(tk_view)
  );

  ////////////////////////////////////////////////////////////////////////
  // power sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sleep_cmd && sleep_ok)
          next_state = ST_WATCH;
      end
      ST_WATCH: begin
        if (wake_ok) begin
          if (pwr1[`LPSW_P1_LOW_SPEED_SELECT])
            next_state = ST_SAMPLE;
          else
            next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_cnt <= 12'h001)
          next_state = ST_ACTIVE;
      end
      ST_SAMPLE: begin
        if (seq_start)
          next_state = ST_CONVERT;
        else
          next_state = ST_WATCH;
      end
      ST_CONVERT: begin
        if (!sar_busy)
          next_state = ST_WATCH;
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_ACTIVE;
      settle_cnt <= 12'h000;
      cmp_sample <= 1'b0;
      cpu_halted <= 1'b0;
      main_osc_run <= 1'b1;
      medium_speed <= 1'b0;
      module_clock_enable_first <= `LPSW_CKSTP_RESET;
      module_clock_enable_second <= `LPSW_CKSTP_RESET;
    end else begin
      state <= next_state;
      if (state == ST_WATCH && wake_ok) begin
        settle_cnt <= settle_cycles(pwr1[`LPSW_P1_STS_LSB +: 3]);
        medium_speed <= pwr2[`LPSW_P2_MEDIUM_SPEED_SELECT];
      end else if (settle_cnt != 12'h000) begin
        settle_cnt <= settle_cnt - 12'h001;
      end
      // one sample per wake, taken as the wake is accepted
      if (state == ST_WATCH && next_state == ST_SAMPLE)
        cmp_sample <= cmp_res[0];
      cpu_halted <= (next_state == ST_WATCH);
      main_osc_run <= (next_state == ST_ACTIVE) ||
                      (next_state == ST_SETTLE);
      if (next_state == ST_WATCH) begin
        module_clock_enable_first <= ckstp1 & `LPSW_CK_WATCH_MASK;
        module_clock_enable_second <= 8'h00;
      end else begin
        module_clock_enable_first <= ckstp1;
        module_clock_enable_second <= ckstp2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparators track their inputs while enabled and clocked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_res <= 2'h0;
    end else if (ckstp1[`LPSW_CK_CMP]) begin
      if (cmp_ctl0[`LPSW_CC_EN])
        cmp_res[0] <= cmp_next(comparator_input_0, cmp_ctl0,
                               cmp_res[0]);
      if (cmp_ctl1[`LPSW_CC_EN])
        cmp_res[1] <= cmp_next(comparator_input_1, cmp_ctl1, cmp_res[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ctl0 <= 16'h0000;
      cmp_ctl1 <= 16'h0000;
      adc_mode <= 6'h00;
      adc_channel <= 3'h0;
      tk_ctl <= 2'h0;
      tk_clear <= 1'b0;
      irq_ctl <= 8'h00;
      irq_flags <= 8'h00;
      tk_use_watch <= 1'b1;
      pwr1 <= 8'h00;
      pwr2 <= 2'h0;
      ckstp1 <= `LPSW_CKSTP_RESET;
      ckstp2 <= `LPSW_CKSTP_RESET;
      wake_ctl <= 2'h0;
    end else begin
      tk_clear <= 1'b0;
      // a flag raised in the cycle of its clear survives
      if (wr_fire && paddr == `LPSW_OFF_IRQ_FLAGS)
        irq_flags <= (irq_flags & ~pwdata[7:0]) | flag_set;
      else
        irq_flags <= irq_flags | flag_set;
      if (wr_fire) begin
        if (paddr == `LPSW_OFF_CMP_CTL0) begin
          cmp_ctl0 <= pwdata[15:0];
        end else if (paddr == `LPSW_OFF_CMP_CTL1) begin
          cmp_ctl1 <= pwdata[15:0];
        end else if (paddr == `LPSW_OFF_ADC_MODE) begin
          adc_mode <= pwdata[5:0];
          // channels past the last one fold back to the last
          if (pwdata[`LPSW_AM_CH_LSB +: 3] > `LPSW_ADC_CH_LAST)
            adc_channel <= `LPSW_ADC_CH_LAST;
          else
            adc_channel <= pwdata[`LPSW_AM_CH_LSB +: 3];
        end else if (paddr == `LPSW_OFF_TK_CTL) begin
          tk_ctl[0] <= pwdata[0];
          tk_clear <= pwdata[1];
        end else if (paddr == `LPSW_OFF_IRQ_CTL) begin
          irq_ctl <= pwdata[7:0];
        end else if (paddr == `LPSW_OFF_TK_CLKSEL) begin
          tk_use_watch <= pwdata[0];
        end else if (paddr == `LPSW_OFF_PWR1) begin
          pwr1 <= pwdata[7:0];
        end else if (paddr == `LPSW_OFF_PWR2) begin
          pwr2 <= pwdata[1:0];
        end else if (paddr == `LPSW_OFF_CKSTP1) begin
          ckstp1 <= pwdata[7:0];
        end else if (paddr == `LPSW_OFF_CKSTP2) begin
          ckstp2 <= pwdata[7:0];
        end else if (paddr == `LPSW_OFF_WAKE_CTL) begin
          wake_ctl <= pwdata[1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; converter result and comparator result registers ignore writes
  always @* begin
    next_rdata = 32'h00000000;
    if (paddr == `LPSW_OFF_CMP_CTL0)
      next_rdata = {16'h0000, cmp_ctl0};
    else if (paddr == `LPSW_OFF_CMP_CTL1)
      next_rdata = {16'h0000, cmp_ctl1};
    else if (paddr == `LPSW_OFF_CMP_RES)
      next_rdata = {30'h00000000, cmp_res};
    else if (paddr == `LPSW_OFF_ADC_MODE)
      next_rdata = {26'h0000000, adc_mode[5:3] > `LPSW_ADC_CH_LAST ?
                    `LPSW_ADC_CH_LAST : adc_mode[5:3], adc_mode[2:0]};
    else if (paddr == `LPSW_OFF_ADC_START)
      next_rdata = {31'h00000000, sar_busy};
    else if (paddr == `LPSW_OFF_ADC_RESULT)
      next_rdata = {16'h0000, sar_result, 6'h00};
    else if (paddr == `LPSW_OFF_TK_CTL)
      next_rdata = {31'h00000000, tk_ctl[0]};
    else if (paddr == `LPSW_OFF_IRQ_CTL)
      next_rdata = {24'h000000, irq_ctl};
    else if (paddr == `LPSW_OFF_IRQ_FLAGS)
      next_rdata = {24'h000000, irq_flags};
    else if (paddr == `LPSW_OFF_TK_CLKSEL)
      next_rdata = {31'h00000000, tk_use_watch};
    else if (paddr == `LPSW_OFF_PWR1)
      next_rdata = {24'h000000, pwr1};
    else if (paddr == `LPSW_OFF_PWR2)
      next_rdata = {30'h00000000, pwr2};
    else if (paddr == `LPSW_OFF_CKSTP1)
      next_rdata = {24'h000000, ckstp1};
    else if (paddr == `LPSW_OFF_CKSTP2)
      next_rdata = {24'h000000, ckstp2};
    else if (paddr == `LPSW_OFF_WAKE_CTL)
      next_rdata = {30'h00000000, wake_ctl};
    else if (paddr == `LPSW_OFF_STATUS)
      next_rdata = {24'h000000, sar_done, cmp_sample, medium_speed, state};
    else if (paddr == `LPSW_OFF_TK_COUNT)
      next_rdata = {12'h000, tk_view};
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data captured with pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !is_mapped(paddr);
      if (rd_setup && !pwrite)
        prdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// [tb/lpsw_sensor.sv]
// model of the analog sensor on comparator input 0 and converter input
`timescale 1ns/1ps
`default_nettype none
module lpsw_sensor (
  input wire logic [9:0] level,
  input wire logic [9:0] dac_code,
  output logic [9:0] sense_out,
  output logic above_trial
);
  // one sensor feeds both paths, as on the board
  assign sense_out = level;
  assign above_trial = level >= dac_code;
endmodule
`default_nettype wire

// [tb/lpsw_top_monitor.sv]
// assertion checker bound to the sensor wake sampler top
`timescale 1ns/1ps
`default_nettype none
module lpsw_top_monitor #(
  parameter QUARTER_TICKS = 8192
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] adc_channel,
  input wire cpu_halted,
  input wire main_osc_run,
  input wire [7:0] module_clock_enable_first,
  input wire [7:0] module_clock_enable_second
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_holds: assert property (!pready |-> $stable(prdata))
    else $error("prdata moved outside an answer");
  a_watch_osc_off: assert property (cpu_halted |-> !main_osc_run)
    else $error("main oscillator running while halted");
  a_watch_gate_one: assert property (
    cpu_halted && $past(cpu_halted) |->
      (module_clock_enable_first & 8'hE0) == 8'h00)
    else $error("non-watch module clock running in watch");
  a_watch_gate_two: assert property (
    cpu_halted && $past(cpu_halted) |-> module_clock_enable_second == 8'h00)
    else $error("second clock group running in watch");
  a_channel_range: assert property (adc_channel <= 3'h5)
    else $error("converter channel beyond the sixth");
  a_settle_from_watch: assert property (
    $rose(main_osc_run) |-> $past(cpu_halted))
    else $error("oscillator started other than on a watch exit");
endmodule
bind lpsw_top lpsw_top_monitor #(.QUARTER_TICKS(QUARTER_TICKS)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_channel(adc_channel), .cpu_halted(cpu_halted),
  .main_osc_run(main_osc_run),
  .module_clock_enable_first(module_clock_enable_first),
  .module_clock_enable_second(module_clock_enable_second)
);
`default_nettype wire

// [tb/test_lpsw_top.sv]
// self-checking bench for the sensor wake sampler
`timescale 1ns/1ps
`default_nettype none
`include "lpsw_consts.vh"
module test_lpsw_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tick_on = 1'b0;
  logic watch_tick = 1'b0;
  logic alt_tick = 1'b0;
  logic [9:0] level = 10'h000;
  logic [3:0] tcnt = 4'h0;
  logic ext_trig = 1'b0;
  logic [31:0] rd;
  logic er;
  logic lost;
  int bad_count = 0;
  int num_checks = 0;
  wire [31:0] prdata;
  wire pready, pslverr, adc_compare, cpu_halted, main_osc_run, medium_speed;
  wire [9:0] sense, dac;
  wire [2:0] adc_channel;
  wire [7:0] ck1, ck2;
  always #5 pclk = ~pclk;
  // quarter event every 64 cycles with four ticks per quarter
  always @(posedge pclk) begin
    tcnt <= tcnt + 4'h1;
    watch_tick <= tick_on && (tcnt == 4'h0);
    alt_tick <= tcnt[0];
  end
  lpsw_sensor u_sensor (.level(level), .dac_code(dac),
    .sense_out(sense), .above_trial(adc_compare));
  lpsw_top #(.QUARTER_TICKS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_input_0(sense),
    .comparator_input_1(10'h000), .watch_tick(watch_tick),
    .alt_tick(alt_tick), .adc_compare(adc_compare),
    .adc_ext_trigger(ext_trig), .adc_channel(adc_channel),
    .adc_dac_code(dac), .cpu_halted(cpu_halted),
    .main_osc_run(main_osc_run), .medium_speed(medium_speed),
    .module_clock_enable_first(ck1), .module_clock_enable_second(ck2));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait count: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    while (cpu_halted !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, cpu_halted}, {31'h0, v});
  endtask
  task automatic wait_adc();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100) begin
      apb(1'b0, `LPSW_OFF_ADC_START, 32'h0);
      n++;
    end
    check(rd, 32'h0);
  endtask
  initial begin
    #500000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`LPSW_OFF_CKSTP1, 32'hFF);
    rdchk(`LPSW_OFF_TK_CLKSEL, 32'h1);
    rdchk(`LPSW_OFF_STATUS, 32'h1);
    apb(1'b0, 8'h48, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("test reset done");
    level <= 10'h096;
    wr(`LPSW_OFF_CMP_CTL0, 32'h1901);
    rdchk(`LPSW_OFF_CMP_RES, 32'h1);
    wr(`LPSW_OFF_CMP_CTL0, 32'h1903);
    level <= 10'h05F;
    rdchk(`LPSW_OFF_CMP_RES, 32'h1);
    wr(`LPSW_OFF_CMP_CTL0, 32'h1901);
    rdchk(`LPSW_OFF_CMP_RES, 32'h0);
    $display("test comparator done");
    level <= 10'h2A5;
    wr(`LPSW_OFF_ADC_MODE, 32'h18);
    wr(`LPSW_OFF_ADC_START, 32'h1);
    check({29'h0, adc_channel}, 32'h3);
    wait_adc();
    rdchk(`LPSW_OFF_ADC_RESULT, 32'hA940);
    wr(`LPSW_OFF_ADC_RESULT, 32'h0);
    rdchk(`LPSW_OFF_ADC_RESULT, 32'hA940);
    level <= 10'h111;
    wr(`LPSW_OFF_ADC_START, 32'h1);
    wr(`LPSW_OFF_ADC_START, 32'h0);
    rdchk(`LPSW_OFF_ADC_START, 32'h0);
    rdchk(`LPSW_OFF_ADC_RESULT, 32'hA940);
    wr(`LPSW_OFF_CKSTP1, 32'hDF);
    wr(`LPSW_OFF_ADC_START, 32'h1);
    rdchk(`LPSW_OFF_ADC_START, 32'h0);
    wr(`LPSW_OFF_CKSTP1, 32'hFF);
    // channel 7 folds to 5; slower bit time; start from the trigger pin
    wr(`LPSW_OFF_ADC_MODE, 32'h3D);
    rdchk(`LPSW_OFF_ADC_MODE, 32'h2D);
    check({29'h0, adc_channel}, 32'h5);
    ext_trig <= 1'b1;
    @(posedge pclk);
    ext_trig <= 1'b0;
    wait_adc();
    rdchk(`LPSW_OFF_ADC_RESULT, 32'h4440);
    $display("test converter done");
    level <= 10'h0C8;
    tick_on <= 1'b1;
    wr(`LPSW_OFF_TK_CTL, 32'h1);
    wr(`LPSW_OFF_IRQ_CTL, 32'h1);
    wr(`LPSW_OFF_WAKE_CTL, 32'h1);
    wr(`LPSW_OFF_PWR1, 32'hC0);
    wr(`LPSW_OFF_PWR2, 32'h1);
    wr(`LPSW_OFF_SLEEP, 32'h0);
    rdchk(`LPSW_OFF_STATUS, 32'h1);
    wr(`LPSW_OFF_PWR2, 32'h0);
    wr(`LPSW_OFF_SLEEP, 32'h0);
    wait_halt(1'b1);
    wait_halt(1'b0);
    wait_halt(1'b1);
    rdchk(`LPSW_OFF_ADC_RESULT, 32'h3200);
    level <= 10'h028;
    wait_halt(1'b0);
    wait_halt(1'b1);
    rdchk(`LPSW_OFF_ADC_RESULT, 32'h3200);
    rdchk(`LPSW_OFF_STATUS, 32'h2);
    wr(`LPSW_OFF_WAKE_CTL, 32'h3);
    wr(`LPSW_OFF_IRQ_FLAGS, 32'h1);
    lost = 1'b0;
    repeat (150) begin
      @(posedge pclk);
      if (cpu_halted !== 1'b1)
        lost = 1'b1;
    end
    check({31'h0, lost}, 32'h0);
    check({24'h0, ck1}, 32'h1F);
    rdchk(`LPSW_OFF_IRQ_FLAGS, 32'h1);
    wr(`LPSW_OFF_PWR1, 32'h80);
    wr(`LPSW_OFF_PWR2, 32'h2);
    wr(`LPSW_OFF_IRQ_FLAGS, 32'h1);
    wr(`LPSW_OFF_WAKE_CTL, 32'h1);
    wait_halt(1'b0);
    repeat (20) @(posedge pclk);
    check({31'h0, main_osc_run}, 32'h1);
    check({31'h0, medium_speed}, 32'h1);
    rdchk(`LPSW_OFF_STATUS, 32'h21);
    $display("test sequencer done");
    wr(`LPSW_OFF_TK_CLKSEL, 32'h0);
    wr(`LPSW_OFF_IRQ_CTL, 32'h80);
    wr(`LPSW_OFF_IRQ_FLAGS, 32'hFF);
    repeat (600) @(posedge pclk);
    apb(1'b0, `LPSW_OFF_IRQ_FLAGS, 32'h0);
    check(rd & 32'h80, 32'h80);
    wr(`LPSW_OFF_TK_CTL, 32'h2);
    rdchk(`LPSW_OFF_TK_COUNT, 32'h0);
    rdchk(`LPSW_OFF_TK_CTL, 32'h0);
    $display("test counter done");
    conclude();
  end
endmodule
`default_nettype wire
